// File: rsb_pkg.sv
package rsb_pkg;

    // ------------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] RSB_OFF_CONFIG = 8'h40;
    localparam logic [7:0] RSB_OFF_STATUS = 8'h41;
    localparam logic [7:0] RSB_OFF_ADDR_CTRL = 8'h42;
    localparam logic [7:0] RSB_OFF_DATA_BUF = 8'h43;
    localparam int RSB_BIT_VIEW_SEL = 6;
    localparam int RSB_BIT_IRQ_EN = 5;
    localparam int RSB_BIT_ESF = 2;
    localparam int RSB_BIT_PER_CHANNEL_FUNC_EN_EN = 0;
    localparam int RSB_BIT_BUSY = 7;
    localparam int RSB_BIT_RNW = 7;
    localparam logic [7:0] RSB_CONFIG_RESET = 8'h00;
    localparam logic [7:0] RSB_ADDR_CTRL_RESET = 8'h00;
    localparam logic [7:0] RSB_DATA_BUF_RESET = 8'h00;
    localparam logic [7:0] RSB_CONFIG_MASK = 8'h65;
    localparam int RSB_CHANNELS = 24;

    // ------------------------------------------------------------------
    // Indirect space
    // ------------------------------------------------------------------
    localparam logic [6:0] RSB_IND_SIGA_LO = 7'h01;
    localparam logic [6:0] RSB_IND_SIGA_HI = 7'h18;
    localparam logic [6:0] RSB_IND_SIGB_LO = 7'h21;
    localparam logic [6:0] RSB_IND_SIGB_HI = 7'h38;
    localparam logic [6:0] RSB_IND_CFG_LO = 7'h41;
    localparam logic [6:0] RSB_IND_CFG_HI = 7'h58;
    localparam logic [6:0] RSB_IND_VALID_LO = 7'h20;
    localparam logic [6:0] RSB_IND_VALID_HI = 7'h57;
    localparam int RSB_DEBOUNCE_SAMPLES = 2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int RSB_CLK_PERIOD_NS = 10;
    localparam int RSB_OP_CYCLE_NS = 650;
    localparam int RSB_READ_DATA_NS = 640;
    localparam int RSB_OP_CYCLES = (RSB_OP_CYCLE_NS + RSB_CLK_PERIOD_NS - 1) / RSB_CLK_PERIOD_NS;
    localparam int RSB_READ_CYCLES = (RSB_READ_DATA_NS + RSB_CLK_PERIOD_NS - 1) / RSB_CLK_PERIOD_NS;
    localparam logic [6:0] RSB_OP_LAST = 7'(RSB_OP_CYCLES - 1);
    localparam logic [6:0] RSB_READ_AT = 7'(RSB_READ_CYCLES - 1);

    typedef enum logic [0:0] {
        RSB_IDLE = 1'b0,
        RSB_BUSY = 1'b1
    } rsb_state_e;

endpackage

// File: rsb_indirect_seq.sv
`timescale 1ns/1ps

// Times one indirect operation: busy for the full operation cycle, with
// pulses for read-data capture and for write commit.
module rsb_indirect_seq (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic start,
    input wire logic read_not_write,
    output logic busy,
    output logic read_strobe,
    output logic write_strobe
);
    import rsb_pkg::*;

    typedef struct packed {
        rsb_state_e state;
        logic [6:0] count;
        logic rnw;
        logic rd;
        logic wr;
    } rsb_seq_s;

    rsb_seq_s seq_reg;
    rsb_seq_s seq_next;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Counts the operation cycle; a start while busy is ignored.
    always_comb begin
        seq_next = seq_reg;
        seq_next.rd = 1'b0;
        seq_next.wr = 1'b0;
        case (seq_reg.state)
            RSB_IDLE: begin
                if (start) begin
                    seq_next.state = RSB_BUSY;
                    seq_next.count = 7'h00;
                    seq_next.rnw = read_not_write;
                    seq_next.wr = ~read_not_write;
                end
            end
            RSB_BUSY: begin
                seq_next.count = seq_reg.count + 7'h01;
                if (seq_reg.rnw && seq_reg.count == RSB_READ_AT - 7'h01) begin // [RQ12]
                    seq_next.rd = 1'b1;
                end
                if (seq_reg.count == RSB_OP_LAST) begin // [RQ6]
                    seq_next.state = RSB_IDLE;
                end
            end
            default: begin
                seq_next.state = RSB_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            seq_reg <= '0;
        end else begin
            seq_reg <= seq_next;
        end
    end

    assign busy = (seq_reg.state == RSB_BUSY);
    assign read_strobe = seq_reg.rd;
    assign write_strobe = seq_reg.wr;

endmodule

// File: rsb_channel_sig.sv
`timescale 1ns/1ps

// Per-channel signaling capture, with optional debounce and SF repeat.
module rsb_channel_sig (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic sample_valid,
    input wire logic [3:0] sample,
    input wire logic func_en,
    input wire logic debounce_en,
    input wire logic esf_sel,
    output logic [3:0] sig_now,
    output logic [3:0] sig_prev,
    output logic changed
);
    import rsb_pkg::*;

    typedef struct packed {
        logic [3:0] last;
        logic [3:0] cur;
        logic [3:0] prev;
        logic chg;
    } rsb_chan_s;

    rsb_chan_s ch_reg;
    rsb_chan_s ch_next;
    logic [3:0] fmt;
    logic accept;

    // ------------------------------------------------------------------
    // Capture
    // ------------------------------------------------------------------
    // In SF the C and D bits repeat A and B; debounce needs two equal samples.
    always_comb begin
        fmt = esf_sel ? sample : {sample[3:2], sample[3:2]};
        accept = !(func_en && debounce_en) || (fmt == ch_reg.last);
        ch_next = ch_reg;
        ch_next.chg = 1'b0;
        if (sample_valid) begin
            ch_next.last = fmt;
            if (accept && fmt != ch_reg.cur) begin
                ch_next.prev = ch_reg.cur;
                ch_next.cur = fmt;
                ch_next.chg = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ch_reg <= '0;
        end else begin
            ch_reg <= ch_next;
        end
    end

    assign sig_now = ch_reg.cur;
    assign sig_prev = ch_reg.prev;
    assign changed = ch_reg.chg;

endmodule

// File: rsb_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: View bit 0 gives indirect window at 41h-43h; 1 gives change flags.
// RQ2: With irq enable set, a change on any of 24 channels raises interrupt.
// RQ3: Format bit selects superframe at 0, extended superframe at 1.
// RQ4: Per-channel functions work only while per-channel enable is 1.
// RQ5: Busy reads 1 during an indirect access; new operations are refused.
// RQ6: Busy falls on a clock edge after the 650 ns operation cycle.
// RQ7: Host waits for busy clear before starting another indirect access.
// RQ8: Top bit of address/control: 0 writes, 1 reads the indirect register.
// RQ9: Low seven bits are indirect address; valid targets are 20h to 57h; the code decodes 01h-18h, 21h-38h and 41h-58h.
// RQ10: For a write, host loads data buffer before writing address/control.
// RQ11: Only an address/control write starts an indirect access.
// RQ12: Read data is in the data buffer 640 ns after the request.
// RQ13: Each change flag reads 1 when the channel's signaling changed.
// RQ14: Reading a change flag register clears all its bits.
// RQ15: Offset 41h shows channels 24 down to 17, channel 24 in bit 7.
// RQ16: 42h shows channels 16..9, 43h channels 8..1, highest in bit 7.
// RQ17: Indirect space holds signaling at 01h-18h/21h-38h, config at 41h-58h.
// RQ18: Debounce accepts new signaling only after 2 identical samples.
// RQ19: In superframe, stored C and D repeat A and B.
// RQ20: Busy sets in the same cycle the address/control write is taken.
// RQ21: Interrupt stays low while enabled and any flag set; releases on clear.
module rsb_regs (
    MCLK,
    RST,
    ADDR,
    WR,
    RD,
    WDATA,
    RDATA,
    INT_N,
    SIG_VALID,
    SIG_CHAN,
    SIG_DATA
);
    import rsb_pkg::*;
    input wire logic MCLK;
    input wire logic RST;
    input wire logic [7:0] ADDR;
    input wire logic WR;
    input wire logic RD;
    input wire logic [7:0] WDATA;
    output logic [7:0] RDATA;
    output logic INT_N;
    input wire logic SIG_VALID;
    input wire logic [4:0] SIG_CHAN;
    input wire logic [3:0] SIG_DATA;

    typedef struct packed {
        logic [7:0] config_r;
        logic [7:0] addr_ctrl;
        logic [7:0] data_buf;
        logic [23:0] flags;
        logic [23:0] debounce;
        logic [7:0] rdata;
        logic int_n;
        logic busy_hold;
    } rsb_regs_s;

    rsb_regs_s r_reg;
    rsb_regs_s r_next;
    logic seq_busy;
    logic rd_strobe;
    logic wr_strobe;
    logic start_op;
    logic view_flags;
    logic [23:0] chg_vec;
    logic [3:0] sig_now [RSB_CHANNELS];
    logic [3:0] sig_prev [RSB_CHANNELS];

    // Maps a channel-relative indirect address to a channel index 0..23.
    function automatic logic [4:0] chan_of(input logic [6:0] a, input logic [6:0] base);
        logic [6:0] d;
        d = a - base;
        return d[4:0];
    endfunction

    // True when an address lies in an inclusive range.
    function automatic logic in_range(input logic [6:0] a, input logic [6:0] lo,
                                      input logic [6:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // ------------------------------------------------------------------
    // Channels and indirect sequencer
    // ------------------------------------------------------------------
    // One capture unit per channel, fed by the received signaling stream.
    // Channel n sits at index n-1, so flag bit n-1 belongs to channel n.
    genvar g;
    generate
        for (g = 0; g < RSB_CHANNELS; g++) begin : g_chan
            rsb_channel_sig u_chan (
                .MCLK(MCLK),
                .RST(RST),
                .sample_valid(SIG_VALID && SIG_CHAN == 5'(g)),
                .sample(SIG_DATA),
                .func_en(r_reg.config_r[RSB_BIT_PER_CHANNEL_FUNC_EN_EN]), // [RQ4]
                .debounce_en(r_reg.debounce[g]), // [RQ18]
                .esf_sel(r_reg.config_r[RSB_BIT_ESF]), // [RQ3] [RQ19]
                .sig_now(sig_now[g]),
                .sig_prev(sig_prev[g]),
                .changed(chg_vec[g])
            );
            // A change pulse always comes with a new value unlike the old one.
            a_chan_changed: assert property (@(posedge MCLK) disable iff (RST) // [RQ13]
                chg_vec[g] |-> sig_now[g] != sig_prev[g]) else $error("change without new value");
        end
    endgenerate

    // The page bit decides which view the three shared offsets show.
    assign view_flags = r_reg.config_r[RSB_BIT_VIEW_SEL];
    // A refused take leaves no trace, so the host has to poll busy first.
    assign start_op = WR && !view_flags && ADDR == RSB_OFF_ADDR_CTRL && !seq_busy
                      && !r_reg.busy_hold; // [RQ11] [RQ5]

    // The sequencer owns the operation timing; this block only reacts to its pulses.
    rsb_indirect_seq u_seq (
        .MCLK(MCLK),
        .RST(RST),
        .start(start_op),
        .read_not_write(WDATA[RSB_BIT_RNW]),
        .busy(seq_busy),
        .read_strobe(rd_strobe),
        .write_strobe(wr_strobe)
    );

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    // Host writes, reads with clear, indirect transfers and interrupt.
    always_comb begin
        logic [6:0] ia;
        logic [4:0] ch;
        logic [7:0] rd_val;
        logic [23:0] clr;
        ia = r_reg.addr_ctrl[6:0];
        ch = 5'h00;
        rd_val = 8'h00;
        clr = 24'h000000;
        r_next = r_reg;
        r_next.busy_hold = start_op; // [RQ20]
        // Host writes; a write to an unmapped offset is dropped.
        if (WR) begin
            if (ADDR == RSB_OFF_CONFIG) begin
                r_next.config_r = WDATA & RSB_CONFIG_MASK;
            end
            if (start_op) begin
                r_next.addr_ctrl = WDATA; // [RQ8] [RQ9]
            end
            if (ADDR == RSB_OFF_DATA_BUF && !view_flags && !seq_busy) begin
                r_next.data_buf = WDATA; // [RQ10]
            end
        end
        // Host read path, view selected by the page bit.
        // Reads of the flag views also mark their byte for clearing.
        case (ADDR)
            RSB_OFF_CONFIG: rd_val = r_reg.config_r;
            RSB_OFF_STATUS: begin
                if (view_flags) begin
                    rd_val = r_reg.flags[23:16]; // [RQ15]
                    clr = 24'hFF0000;
                end else begin
                    rd_val = {seq_busy || r_reg.busy_hold, 7'h00}; // [RQ5] [RQ1]
                end
            end
            RSB_OFF_ADDR_CTRL: begin
                rd_val = view_flags ? r_reg.flags[15:8] : r_reg.addr_ctrl; // [RQ16]
                clr = view_flags ? 24'h00FF00 : 24'h000000;
            end
            RSB_OFF_DATA_BUF: begin
                rd_val = view_flags ? r_reg.flags[7:0] : r_reg.data_buf; // [RQ16]
                clr = view_flags ? 24'h0000FF : 24'h000000;
            end
            default: rd_val = 8'h00;
        endcase
        r_next.rdata = RD ? rd_val : r_reg.rdata;
        // Read clears flags, but a change in the same cycle wins.
        r_next.flags = (r_reg.flags & ~(RD ? clr : 24'h000000)) | chg_vec; // [RQ13] [RQ14]
        // Indirect read completes into the data buffer.
        if (rd_strobe) begin // [RQ12]
            r_next.data_buf = 8'h00;
            if (in_range(ia, RSB_IND_SIGA_LO, RSB_IND_SIGA_HI)) begin
                ch = chan_of(ia, RSB_IND_SIGA_LO);
                r_next.data_buf = {4'h0, sig_now[ch]}; // [RQ17]
            end else if (in_range(ia, RSB_IND_SIGB_LO, RSB_IND_SIGB_HI)) begin
                ch = chan_of(ia, RSB_IND_SIGB_LO);
                r_next.data_buf = {4'h0, sig_now[ch]}; // [RQ17]
            end else if (in_range(ia, RSB_IND_CFG_LO, RSB_IND_CFG_HI)) begin
                ch = chan_of(ia, RSB_IND_CFG_LO);
                r_next.data_buf = {7'h00, r_reg.debounce[ch]}; // [RQ17]
            end
        end
        // Indirect write commits bit 0 of the buffered byte to a channel's debounce bit.
        if (wr_strobe && in_range(ia, RSB_IND_CFG_LO, RSB_IND_CFG_HI)) begin // [RQ8]
            ch = chan_of(ia, RSB_IND_CFG_LO);
            r_next.debounce[ch] = r_reg.data_buf[0]; // [RQ18]
        end
        // Interrupt while enabled and any flag remains set.
        r_next.int_n = !(r_next.config_r[RSB_BIT_IRQ_EN] && |r_next.flags); // [RQ2] [RQ21]
    end

    // Registers the whole state; reset leaves the interrupt released.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            r_reg <= '0;
            r_reg.int_n <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Both outputs come straight from the state register.
    assign RDATA = r_reg.rdata;
    assign INT_N = r_reg.int_n;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_start;
        start_op;
    endsequence

    sequence s_busy_run;
        seq_busy [*8];
    endsequence

    a_busy_on_start: assert property (@(posedge MCLK) disable iff (RST) // [RQ20]
        start_op |=> r_reg.busy_hold && seq_busy) else $error("busy not set on start");
    a_busy_held: assert property (@(posedge MCLK) disable iff (RST) // [RQ5]
        s_start |=> s_busy_run) else $error("busy dropped early");
    a_busy_ends: assert property (@(posedge MCLK) disable iff (RST) // [RQ6]
        start_op |-> ##65 seq_busy ##1 !seq_busy) else $error("busy did not clear in time");
    a_read_timed: assert property (@(posedge MCLK) disable iff (RST) // [RQ12]
        start_op && WDATA[7] |-> ##64 rd_strobe) else $error("read data late");
    a_no_restart: assert property (@(posedge MCLK) disable iff (RST) // [RQ11]
        seq_busy && WR && ADDR == RSB_OFF_ADDR_CTRL |=> $stable(r_reg.addr_ctrl))
        else $error("start while busy");
    a_flag_sets: assert property (@(posedge MCLK) disable iff (RST) // [RQ13]
        |chg_vec |=> |r_reg.flags) else $error("change flag lost");
    a_irq_drive: assert property (@(posedge MCLK) disable iff (RST) // [RQ2]
        r_reg.config_r[5] && |r_reg.flags |-> !INT_N) else $error("interrupt missing");
    a_irq_quiet: assert property (@(posedge MCLK) disable iff (RST) // [RQ21]
        !r_reg.config_r[5] |-> INT_N) else $error("interrupt while disabled");
    a_read_clears: assert property (@(posedge MCLK) disable iff (RST) // [RQ14]
        RD && view_flags && ADDR == 8'h43 && chg_vec[7:0] == 8'h00
        |=> r_reg.flags[7:0] == 8'h00) else $error("flags not cleared");

    // Host-visible views of the shared offsets and the configuration write.
    sequence s_status_read;
        RD && !view_flags && ADDR == RSB_OFF_STATUS;
    endsequence

    sequence s_flags_hi_read;
        RD && view_flags && ADDR == RSB_OFF_STATUS;
    endsequence

    sequence s_flags_mid_read;
        RD && view_flags && ADDR == RSB_OFF_ADDR_CTRL;
    endsequence

    sequence s_cfg_write;
        WR && ADDR == RSB_OFF_CONFIG;
    endsequence

    // The status view keeps its reserved bits at zero and shows busy during a run.
    a_status_view: assert property (@(posedge MCLK) disable iff (RST) // [RQ1]
        s_status_read |=> RDATA[6:0] == 7'h00) else $error("status reserved bits set");
    a_busy_status: assert property (@(posedge MCLK) disable iff (RST) // [RQ5]
        s_status_read ##0 seq_busy |=> RDATA[RSB_BIT_BUSY]) else $error("busy not shown");
    // The top flag view hands over the flags as they stood on the read edge; a middle view read clears its byte.
    a_flags_hi: assert property (@(posedge MCLK) disable iff (RST) // [RQ15]
        s_flags_hi_read |=> RDATA == $past(r_reg.flags[23:16])) else $error("flag byte wrong");
    a_flags_mid: assert property (@(posedge MCLK) disable iff (RST) // [RQ16]
        s_flags_mid_read ##0 chg_vec[15:8] == 8'h00 |=> r_reg.flags[15:8] == 8'h00)
        else $error("middle flags not cleared");
    // Only the writable bits of the configuration are kept.
    a_cfg_masked: assert property (@(posedge MCLK) disable iff (RST) // [RQ3] [RQ4]
        s_cfg_write |=> r_reg.config_r == ($past(WDATA) & RSB_CONFIG_MASK))
        else $error("config write wrong");
    // An enabled change drives the interrupt on the next edge.
    a_irq_follows: assert property (@(posedge MCLK) disable iff (RST) // [RQ2]
        r_reg.config_r[RSB_BIT_IRQ_EN] && |chg_vec && !(WR && ADDR == RSB_OFF_CONFIG)
        |=> !INT_N) else $error("interrupt late");
    // A busy sequencer leaves the data buffer to itself.
    a_data_refused: assert property (@(posedge MCLK) disable iff (RST) // [RQ5]
        seq_busy && !rd_strobe |=> $stable(r_reg.data_buf))
        else $error("data buffer overwritten");
    // An indirect write to the first channel's configuration lands one edge after the take.
    a_write_commit: assert property (@(posedge MCLK) disable iff (RST) // [RQ8] [RQ18]
        wr_strobe && r_reg.addr_ctrl[6:0] == RSB_IND_CFG_LO
        |=> r_reg.debounce[0] == $past(r_reg.data_buf[0])) else $error("write not committed");
    // An indirect read of the first channel's configuration returns its debounce bit.
    a_read_cfg: assert property (@(posedge MCLK) disable iff (RST) // [RQ12] [RQ17]
        rd_strobe && r_reg.addr_ctrl[6:0] == RSB_IND_CFG_LO
        |=> r_reg.data_buf == {7'h00, $past(r_reg.debounce[0])}) else $error("read data wrong");
    // A change on the read edge survives the clear.
    a_flag_keep: assert property (@(posedge MCLK) disable iff (RST) // [RQ13] [RQ14]
        RD && view_flags && ADDR == RSB_OFF_DATA_BUF && chg_vec[0] |=> r_reg.flags[0])
        else $error("change lost on clear");
    // With every flag clear the interrupt is released.
    a_irq_release: assert property (@(posedge MCLK) disable iff (RST) // [RQ21]
        r_reg.flags == 24'h000000 |-> INT_N) else $error("interrupt held without flags");

endmodule

// File: rsb_host_model.sv
`timescale 1ns/1ps

// Behavioural host processor on the byte register bus.
// Strobes last one cycle, and inputs move 1 ns after the clock edge.
module rsb_host_model (
    input wire logic mclk,
    input wire logic [7:0] rdata,
    output logic [7:0] addr,
    output logic wr,
    output logic rd,
    output logic [7:0] wdata
);
    import rsb_pkg::*;

    // The bus starts idle at time zero.
    initial begin
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end

    // Writes one byte; the strobe is held through the edge that takes it.
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge mclk);
        #1;
        wr = 1'b0;
    endtask

    // Reads one byte; the data is registered, so it is taken one edge after the strobe.
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge mclk);
        #1;
        rd = 1'b0;
        @(posedge mclk);
        #1;
        d = rdata;
    endtask

    // Polls the status byte until busy drops; the bound keeps a stuck flag from hanging.
    task automatic wait_idle(output int polls);
        logic [7:0] s;
        polls = 0;
        s = 8'h80;
        while (s[RSB_BIT_BUSY] !== 1'b0 && polls < 100) begin
            reg_rd(RSB_OFF_STATUS, s);
            polls++;
        end
    endtask

    // Runs one whole indirect operation and returns the data buffer on a read.
    task automatic ind_op(input logic rnw, input logic [6:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        int polls;
        wait_idle(polls);
        if (!rnw) begin
            reg_wr(RSB_OFF_DATA_BUF, d);
        end
        reg_wr(RSB_OFF_ADDR_CTRL, {rnw, a});
        wait_idle(polls);
        q = 8'h00;
        if (rnw) begin
            reg_rd(RSB_OFF_DATA_BUF, q);
        end
    endtask
endmodule

// File: rsb_regs_bench.sv
`timescale 1ns/1ps

module rsb_regs_bench;
    import rsb_pkg::*;

    // ------------------------------------------------------------------
    // Clock, reset and wiring
    // ------------------------------------------------------------------
    logic mclk;
    logic rst;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic int_n;
    logic sig_valid;
    logic [4:0] sig_chan;
    logic [3:0] sig_data;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;

    // The clock toggles every half period of 10 ns.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Edge counter used to time the busy span.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
    end

    rsb_regs dut (.MCLK(mclk), .RST(rst), .ADDR(addr), .WR(wr), .RD(rd), .WDATA(wdata),
                  .RDATA(rdata), .INT_N(int_n), .SIG_VALID(sig_valid),
                  .SIG_CHAN(sig_chan), .SIG_DATA(sig_data));

    rsb_host_model host (.mclk(mclk), .rdata(rdata), .addr(addr), .wr(wr), .rd(rd),
                         .wdata(wdata));

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    // Compares one byte and reports a mismatch at once.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reads a register and compares it.
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.reg_rd(a, d);
        chk(what, exp, d);
    endtask

    // Sends one signaling sample, then lets the flag and interrupt settle.
    task automatic sig(input logic [4:0] ch, input logic [3:0] d);
        @(posedge mclk);
        #1;
        sig_valid = 1'b1;
        sig_chan = ch;
        sig_data = d;
        @(posedge mclk);
        #1;
        sig_valid = 1'b0;
        repeat (4) @(posedge mclk);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, the writable config bits and an unmapped offset.
    task automatic t_reset();
        rd_chk("config", RSB_OFF_CONFIG, 8'h00);
        rd_chk("status", RSB_OFF_STATUS, 8'h00);
        rd_chk("addr ctrl", RSB_OFF_ADDR_CTRL, 8'h00);
        rd_chk("unmapped", 8'h44, 8'h00);
        host.reg_wr(RSB_OFF_CONFIG, 8'hFF);
        rd_chk("config mask", RSB_OFF_CONFIG, 8'h65);
        host.reg_wr(RSB_OFF_CONFIG, 8'h00);
    endtask

    // Busy span of an indirect write, refusal while busy, then read-back.
    task automatic t_busy();
        logic [7:0] s;
        int t0;
        int p;
        host.reg_wr(RSB_OFF_DATA_BUF, 8'h01);
        host.reg_wr(RSB_OFF_ADDR_CTRL, 8'h41);
        t0 = cyc;
        host.reg_rd(RSB_OFF_STATUS, s);
        chk("busy at start", 8'h80, s & 8'h80);
        host.reg_wr(RSB_OFF_DATA_BUF, 8'hAA);
        host.reg_wr(RSB_OFF_ADDR_CTRL, 8'hA2);
        host.wait_idle(p);
        chk("busy span ok", 8'h01, {7'h00, (cyc - t0 >= 66) && (cyc - t0 <= 72)});
        rd_chk("data kept", RSB_OFF_DATA_BUF, 8'h01);
        rd_chk("addr kept", RSB_OFF_ADDR_CTRL, 8'h41);
        host.ind_op(1'b1, 7'h41, 8'h00, s);
        chk("chan cfg", 8'h01, s);
    endtask

    // Superframe repeats A and B into C and D; extended superframe keeps all four.
    task automatic t_format();
        logic [7:0] q;
        host.reg_wr(RSB_OFF_CONFIG, 8'h01);
        sig(5'd1, 4'hC);
        host.ind_op(1'b1, 7'h22, 8'h00, q);
        chk("sf sig ch2", 8'h0F, q);
        host.reg_wr(RSB_OFF_CONFIG, 8'h05);
        sig(5'd2, 4'hC);
        host.ind_op(1'b1, 7'h23, 8'h00, q);
        chk("esf sig ch3", 8'h0C, q);
    endtask

    // Debounce, flag placement, interrupt level and clear on read.
    task automatic t_flags();
        logic [7:0] d;
        host.reg_wr(RSB_OFF_CONFIG, 8'h61);
        host.reg_rd(RSB_OFF_STATUS, d);
        host.reg_rd(RSB_OFF_ADDR_CTRL, d);
        host.reg_rd(RSB_OFF_DATA_BUF, d);
        sig(5'd0, 4'h5);
        chk("irq after one sample", 8'h01, {7'h00, int_n});
        sig(5'd0, 4'h5);
        sig(5'd23, 4'hC);
        sig(5'd8, 4'hC);
        chk("irq raised", 8'h00, {7'h00, int_n});
        rd_chk("flags 24..17", RSB_OFF_STATUS, 8'h80);
        rd_chk("flags 16..9", RSB_OFF_ADDR_CTRL, 8'h01);
        chk("irq held", 8'h00, {7'h00, int_n});
        rd_chk("flags 8..1", RSB_OFF_DATA_BUF, 8'h01);
        chk("irq released", 8'h01, {7'h00, int_n});
        rd_chk("flags cleared", RSB_OFF_STATUS, 8'h00);
    endtask

    // Without per-channel functions debounce is off; without enable no interrupt.
    task automatic t_nopcce();
        host.reg_wr(RSB_OFF_CONFIG, 8'h40);
        sig(5'd0, 4'hA);
        chk("irq disabled", 8'h01, {7'h00, int_n});
        rd_chk("flag no debounce", RSB_OFF_DATA_BUF, 8'h01);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    // Holds reset for 8 cycles, then runs every scenario in turn.
    initial begin
        rst = 1'b1;
        sig_valid = 1'b0;
        sig_chan = 5'h00;
        sig_data = 4'h0;
        repeat (8) @(posedge mclk);
        #1;
        rst = 1'b0;
        t_reset();
        t_busy();
        t_format();
        t_flags();
        t_nopcce();
        test_done();
    end

    // The scenarios need well under a thousand cycles; 20000 means a hang.
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
endmodule
